// ==== design/fan_pwm_tach.sv ====
// fan_pwm_tach: fan drive pwm generator with tachometer period counter,
// programmed over a plain register port (read data one cycle after strobe).
// assumes tachIn is already synchronous to clk.
// limitation: writes take effect mid-period, so the period in flight may
// end with a runt or stretched pulse; no shadow register, to keep it small.
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module fan_pwm_tach (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [fan_pwm_pkg::ADDR_W-1:0] regAddr,
  input wire logic [fan_pwm_pkg::DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [fan_pwm_pkg::DATA_W-1:0] regRdData,
  input wire logic tachIn,
  output logic fanDriveOutput
);
  import fan_pwm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // mask of the low 'exp' bits; used for both prescalers
  function automatic logic [PWM_PRE_W-1:0] lowMask(input logic [3:0] exp);
    logic [PWM_PRE_W-1:0] m;
    m = '0;
    for (int i = 0; i < PWM_PRE_W; i++) begin
      if (i < int'(exp)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : lowMask

  // a prescaler finishes its span on a base tick once its low 'exp' bits are all set
  function automatic logic prescaleDue(input logic baseTick, input logic [PWM_PRE_W-1:0] pre,
    input logic [PWM_PRE_W-1:0] mask);
    return baseTick && ((pre & mask) == mask);
  endfunction : prescaleDue

  ////////////////////////////////////////////////////////////////////////////
  // types

  typedef struct packed {
    // software registers
    logic [7:0] fanDrive;
    logic [7:0] fanCtrl;
    // pwm generator
    logic [PWM_PRE_W-1:0] pwmPre;
    logic [DUTY_W-1:0] pwmStep;
    logic fanOut;
    // tachometer
    logic [TACH_PRE_W-1:0] tachPre;
    logic tachSample;
    logic [TACH_COUNT_W-1:0] tachRun;
    logic [TACH_COUNT_W-1:0] tachCount;
    logic tachFresh;
    // read port
    logic [DATA_W-1:0] rdData;
  } fan_state_t;

  // drive level for the current step; force wins over the duty code
  function automatic logic driveLevel(input logic [DATA_W-1:0] drive, input logic [DUTY_W-1:0] step);
    logic [DUTY_W-1:0] code;
    logic level;
    code = drive[DUTY_LSB +: DUTY_W];
    if (drive[FORCE_HIGH_BIT]) begin
      level = 1'b1;
    end else if (code == 6'h00) begin
      level = 1'b0;
    end else begin
      // high for 'code' of the 64 steps
      level = (step < code);
    end
    return level;
  endfunction : driveLevel

  // read view of the registers; unmapped indices read as zero
  function automatic logic [DATA_W-1:0] readReg(input logic [ADDR_W-1:0] addr, input fan_state_t st);
    logic [DATA_W-1:0] d;
    d = '0;
    unique case (addr)
      FAN_DRIVE_ADDR: d = st.fanDrive;
      FAN_CTRL_ADDR: d = st.fanCtrl;
      TACH_COUNT_ADDR: d = st.tachCount;
      TACH_STATUS_ADDR: d = {7'h00, st.tachFresh};
      default: d = '0;
    endcase
    return d;
  endfunction : readReg

  fan_state_t state;
  fan_state_t next_state;

  logic pwmBaseTick;
  logic tachBaseTick;

  ////////////////////////////////////////////////////////////////////////////
  // time bases

  tick_divider pwmBase (
    .clk(clk),
    .rst_b(rst_b),
    .period(TICK_W'(PWM_STEP_CYCLES)),
    .tick(pwmBaseTick)
  );

  tick_divider tachBase (
    .clk(clk),
    .rst_b(rst_b),
    .period(TICK_W'(TACH_CLOCK_CYCLES)),
    .tick(tachBaseTick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic [3:0] pwmExp;
  logic [PWM_PRE_W-1:0] pwmMask;
  logic pwmStepTick;
  logic [PWM_PRE_W-1:0] tachMask;
  logic tachTick;
  logic tachRise;

  always_comb begin
    next_state = state;

    // exponent above 10 would exceed the longest period, so clamp it
    pwmExp = state.fanCtrl[PWM_EXP_LSB +: PWM_EXP_W];
    if (pwmExp > PWM_EXP_MAX) begin
      pwmExp = PWM_EXP_MAX;
    end
    pwmMask = lowMask(pwmExp);
    pwmStepTick = prescaleDue(pwmBaseTick, state.pwmPre, pwmMask);
    tachMask = lowMask({2'b00, state.fanCtrl[TACH_DIV_LSB +: TACH_DIV_W]});
    tachTick = prescaleDue(tachBaseTick, PWM_PRE_W'(state.tachPre), tachMask);
    tachRise = 1'b0;

    // pwm prescaler and 64-step period counter
    if (pwmBaseTick) begin
      next_state.pwmPre = (pwmStepTick) ? '0 : state.pwmPre + 10'h001;
    end
    if (pwmStepTick) begin
      next_state.pwmStep = state.pwmStep + 6'h01;
    end

    next_state.fanOut = driveLevel(state.fanDrive, state.pwmStep);

    // tachometer: sample once per count clock, so pulses must span
    // at least one count clock to be sure of being seen; shorter glitches can be missed
    // the first reading after reset spans a partial period
    if (tachBaseTick) begin
      next_state.tachPre = (tachTick) ? '0 : state.tachPre + 3'h1;
    end
    if (tachTick) begin
      next_state.tachSample = tachIn;
      tachRise = tachIn && !state.tachSample;
      if (tachRise) begin
        next_state.tachCount = state.tachRun;
        next_state.tachRun = 8'h01;
        next_state.tachFresh = 1'b1;
      end else if (state.tachRun != 8'hff) begin
        next_state.tachRun = state.tachRun + 8'h01;
      end
    end else if (state.tachRun == 8'hff) begin
      // stopped fan: report full scale instead of a stale reading
      next_state.tachCount = 8'hff;
    end

    // register writes
    if (regWr) begin
      unique case (regAddr)
        FAN_DRIVE_ADDR: next_state.fanDrive = regWrData;
        FAN_CTRL_ADDR: next_state.fanCtrl = regWrData;
        TACH_STATUS_ADDR: begin
          // write one to clear; a new reading in the same cycle wins
          if (regWrData[FRESH_BIT] && !tachRise) begin
            next_state.tachFresh = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // register reads, answered in the next cycle
    next_state.rdData = '0;
    if (regRd) begin
      next_state.rdData = readReg(regAddr, state);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // constants only; the two software registers take their own reset values
      state <= '0;
      state.fanDrive <= FAN_DRIVE_RESET;
      state.fanCtrl <= FAN_CTRL_RESET;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign regRdData = state.rdData;
  assign fanDriveOutput = state.fanOut;

endmodule : fan_pwm_tach

// ==== design/fan_pwm_pkg.sv ====
// fan_pwm_pkg: register map, field layout, reset values and timing counts
// for the fan drive and tachometer block.
// assumes a 100 MHz system clock and an 8-bit register port.
package fan_pwm_pkg;

  localparam int CLK_PERIOD_NS = 10;

  // register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // register indices
  localparam logic [3:0] FAN_DRIVE_ADDR = 4'h0;
  localparam logic [3:0] FAN_CTRL_ADDR = 4'h1;
  localparam logic [3:0] TACH_COUNT_ADDR = 4'h2;
  localparam logic [3:0] TACH_STATUS_ADDR = 4'h3;

  // reset values
  localparam logic [7:0] FAN_DRIVE_RESET = 8'h00;
  localparam logic [7:0] FAN_CTRL_RESET = 8'h00;

  // fan_drive_control fields
  localparam int FORCE_HIGH_BIT = 0;
  localparam int DUTY_LSB = 1;
  localparam int DUTY_W = 6;

  // fan control fields
  localparam int PWM_EXP_LSB = 0;
  localparam int PWM_EXP_W = 4;
  localparam int TACH_DIV_LSB = 4;
  localparam int TACH_DIV_W = 2;
  localparam logic [3:0] PWM_EXP_MAX = 4'ha;

  // status fields
  localparam int FRESH_BIT = 0;

  // pwm: 64 steps per period, step of 330 ns scaled by 2^exp (0..10)
  localparam int PWM_STEP_NS = 330;
  localparam int PWM_STEP_CYCLES = PWM_STEP_NS / CLK_PERIOD_NS;
  localparam int PWM_PRE_W = 10;

  // tachometer count clock base period, 30.52 us, scaled by 2^divisor
  localparam int TACH_CLOCK_PERIOD_NS = 30520;
  localparam int TACH_CLOCK_CYCLES = TACH_CLOCK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TACH_PRE_W = 3;
  localparam int TACH_COUNT_W = 8;

  localparam int TICK_W = 12;

endpackage : fan_pwm_pkg

// ==== design/tick_divider.sv ====
// tick_divider: emits a one-cycle pulse every 'period' clock cycles.
// assumes period is at least 1 and held steady while running.
`timescale 1ns/1ps
module tick_divider (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [fan_pwm_pkg::TICK_W-1:0] period,
  output logic tick
);
  import fan_pwm_pkg::*;

  typedef struct packed {
    logic [TICK_W-1:0] cnt;
    logic tick;
  } div_state_t;

  div_state_t state;
  div_state_t next_state;

  always_comb begin
    next_state = state;
    next_state.tick = 1'b0;
    if (state.cnt >= period - 12'h001) begin
      next_state.cnt = '0;
      next_state.tick = 1'b1;
    end else begin
      next_state.cnt = state.cnt + 12'h001;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign tick = state.tick;

endmodule : tick_divider

// ==== sim/fan_model.sv ====
// fan_model: spinning fan seen through its tachometer output
// assumes clk is the block clock; counts are in clk cycles
`timescale 1ns/1ps
module fan_model #(
  parameter int HI_CYC = 18312,
  parameter int LO_CYC = 6104
) (
  input wire logic clk,
  output logic tachIn
);
  int cnt = 0;
  // 3 count clocks high, 1 low at divisor 1: the shortest pulse still measured
  always @(posedge clk) begin
    cnt <= (cnt == HI_CYC + LO_CYC - 1) ? 0 : cnt + 1;
    tachIn <= cnt < HI_CYC;
  end
endmodule : fan_model

// ==== sim/fan_pwm_tach_sva.sv ====
// fan_pwm_tach_chk: readback and pwm timing checks at the block ports
// assumes the drive and control registers change only by writes at these ports
`timescale 1ns/1ps
module fan_pwm_tach_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [fan_pwm_pkg::ADDR_W-1:0] regAddr,
  input wire logic [fan_pwm_pkg::DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [fan_pwm_pkg::DATA_W-1:0] regRdData,
  input wire logic tachIn,
  input wire logic fanDriveOutput
);
  import fan_pwm_pkg::*;
  logic [7:0] drv;
  logic [7:0] ctl;
  int hi;
  int lo;
  int quiet;
  int step;
  assign step = PWM_STEP_CYCLES << ((ctl[3:0] > PWM_EXP_MAX) ? PWM_EXP_MAX : ctl[3:0]);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      drv <= FAN_DRIVE_RESET;
      ctl <= FAN_CTRL_RESET;
      hi <= 0;
      lo <= 0;
      quiet <= 0;
    end else begin
      if (regWr && regAddr == FAN_DRIVE_ADDR) drv <= regWrData;
      if (regWr && regAddr == FAN_CTRL_ADDR) ctl <= regWrData;
      hi <= fanDriveOutput ? hi + 1 : 0;
      lo <= fanDriveOutput ? 0 : lo + 1;
      // timing checks wait a full period after any write, as a period in flight may be cut short
      quiet <= regWr ? 0 : quiet + 1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  rd_idle_a: assert property (!$past(regRd) |-> regRdData == 8'h00) else $error("read data off slot");
  drv_read_a: assert property ($past(regRd) && $past(regAddr) == FAN_DRIVE_ADDR |-> regRdData == drv)
    else $error("drive readback");
  ctl_read_a: assert property ($past(regRd) && $past(regAddr) == FAN_CTRL_ADDR |-> regRdData == ctl)
    else $error("ctrl readback");
  unmapped_read_a: assert property ($past(regRd) && $past(regAddr) > 4'h3 |-> regRdData == 8'h00)
    else $error("unmapped read");
  status_read_a: assert property ($past(regRd) && $past(regAddr) == TACH_STATUS_ADDR
    |-> regRdData[7:1] == 7'h00) else $error("status readback");
  force_high_a: assert property (drv[0] && quiet > 2 |-> fanDriveOutput) else $error("force high");
  zero_low_a: assert property (drv[6:0] == 7'h00 && quiet > 2 |-> !fanDriveOutput) else $error("zero duty");
  high_time_a: assert property (quiet > 64 * step + 4 && $fell(fanDriveOutput) |-> hi == drv[6:1] * step)
    else $error("high time");
  low_time_a: assert property (quiet > 64 * step + 4 && $rose(fanDriveOutput) |-> lo == (64 - drv[6:1]) * step)
    else $error("low time");
  cover property (quiet > 64 * step && $fell(fanDriveOutput));
  cover property ($past(regRd) && $past(regAddr) == TACH_COUNT_ADDR && regRdData != 8'h00);
  cover property (drv[0] && quiet > 2 && fanDriveOutput);
endmodule : fan_pwm_tach_chk

bind fan_pwm_tach fan_pwm_tach_chk chk (.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
  .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .tachIn(tachIn), .fanDriveOutput(fanDriveOutput));

// ==== sim/fan_pwm_tach_tb_top.sv ====
// fan_pwm_tach_tb_top: register-level tests of duty, force and tach count
// assumes fan_model runs from time zero; ctrl writes keep divisor exponent 1
`timescale 1ns/1ps
module fan_pwm_tach_tb_top;
  import fan_pwm_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWrData = '0;
  logic [DATA_W-1:0] regRdData;
  logic tachIn;
  logic fanDriveOutput;
  int n_mismatch = 0;
  int cmp_count = 0;
  always #5 clk = ~clk;
  fan_pwm_tach DUT (.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .tachIn(tachIn), .fanDriveOutput(fanDriveOutput));
  fan_model fan (.clk(clk), .tachIn(tachIn));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask : rd
  // counts high cycles over one whole period once the new setting has settled
  task automatic duty(input logic [7:0] c, input logic [7:0] d, input int expHigh);
    logic [7:0] v;
    int n;
    int nLow;
    n = 0;
    nLow = 0;
    wr(FAN_CTRL_ADDR, c);
    wr(FAN_DRIVE_ADDR, d);
    rd(FAN_DRIVE_ADDR, v);
    chk("drive reg", {24'h0, d}, {24'h0, v});
    rd(FAN_CTRL_ADDR, v);
    chk("ctrl reg", {24'h0, c}, {24'h0, v});
    repeat (2200 << c[3:0]) @(posedge clk);
    repeat (2112 << c[3:0]) begin
      @(posedge clk);
      // count both levels so an unknown output cannot pass as low
      n += (fanDriveOutput === 1'b1) ? 1 : 0;
      nLow += (fanDriveOutput === 1'b0) ? 1 : 0;
    end
    chk("high cycles", expHigh, n);
    chk("low cycles", (2112 << c[3:0]) - expHigh, nLow);
    $display("duty test %0h/%0h done", c, d);
  endtask : duty
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] v;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    duty(8'h10, 8'h00, 0);
    duty(8'h10, 8'h02, 33);
    duty(8'h10, 8'h7e, 2079);
    duty(8'h10, 8'h01, 2112);
    duty(8'h10, 8'hc1, 2112);
    duty(8'h11, 8'h40, 2112);
    rd(4'h9, v);
    chk("unmapped", 0, {24'h0, v});
    wr(TACH_STATUS_ADDR, 8'h01);
    rd(TACH_STATUS_ADDR, v);
    chk("fresh cleared", 0, {24'h0, v});
    v = 8'h00;
    for (int i = 0; i < 1500 && v[0] !== 1'b1; i++) begin
      repeat (20) @(posedge clk);
      rd(TACH_STATUS_ADDR, v);
    end
    chk("fresh", 1, {31'h0, v[0]});
    rd(TACH_COUNT_ADDR, v);
    chk("tach count", 4, {24'h0, v});
    $display("tach test done");
    results();
  end
  initial begin
    // tests need about 50000 cycles, the tach poll at most 33000 of them
    repeat (90000) @(posedge clk);
    n_mismatch++;
    results();
  end
endmodule : fan_pwm_tach_tb_top
